// File: src/iox_core.sv
`timescale 1ns/1ps
// Operation
// RQ1: the outside party holds the reset pin low for the minimum pulse width.
// RQ2: reset pin low forces every register and bus machine to defaults.
// RQ3: port levels change only while the reset pin is high; the code also forces port_o and port_oe_o to defaults while the pin is low.
// RQ4: any edge on an input-configured pin raises the alert.
// RQ5: alert becomes valid within a bounded delay after the input edge.
// RQ6: alert clears when data returns or the alerting port is read.
// RQ7: read clear happens at the ack or nack bit after scl rises.
// RQ8: after a clear, further input changes raise the alert again.
// RQ9: output-configured pins never contribute to the alert.
// RQ10: switching a pin to input may raise a spurious alert.
// RQ11: alert output only pulls low or releases, never drives high.
// RQ12: the master starts a transfer only while the bus is idle.
// RQ13: write is address with direction 0, then command choosing the register.
// RQ14: successive written bytes alternate between the two registers of a pair.
// RQ15: a write accepts any number of data bytes, alternating each.
// RQ16: read is command write, repeated start, address with direction 1.
// RQ17: each further read byte comes from the other register of the pair.
// RQ18: the master answers the last read byte with not-acknowledge.
// RQ19: after a repeated start, reading resumes at the next register of pair.
// RQ20: pin data is captured into the input register at ack rising edge.
// RQ21: after power-up reset release all registers and bus machine are default.
// RQ22: low three command bits pick one of eight registers; bit 0 picks port.
// RQ23: direction bit 1 makes the pin an input, 0 makes it an output.
// RQ24: inversion bit 1 inverts the pin level in the input register.
// RQ25: output register reads return the written value, not the pin.
// RQ26: alert stays while any input pin differs from the last read snapshot.
module iox_core (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reset_pin_n_i,
  input wire logic addr_sel_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [15:0] port_i,
  output logic [15:0] port_o,
  output logic [15:0] port_oe_o,
  output logic alert_n_o,
  output logic alert_n_oe_o
);

  iox_pkg::iox_core_s s_q;
  iox_pkg::iox_core_s s_d;
  logic [iox_pkg::SYNC_W-1:0] syn;

  // all pins from outside pass the synchroniser
  iox_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({addr_sel_i, reset_pin_n_i, sda_i, scl_i, port_i}),
    .q_o(syn)
  );

  // byte returned for a pointer value
  function automatic logic [7:0] rd_byte(
    input logic [2:0] ptr,
    input logic [15:0] inr,
    input logic [15:0] outr,
    input logic [15:0] inv,
    input logic [15:0] cfg
  );
    logic [15:0] sel;
    sel = cfg;
    case (ptr[2:1])
      2'h0: sel = inr ^ inv; // RQ24
      2'h1: sel = outr; // RQ25
      2'h2: sel = inv;
      default: sel = cfg;
    endcase
    rd_byte = ptr[0] ? sel[15:8] : sel[7:0]; // RQ22
  endfunction : rd_byte

  // a byte of a 16-bit word selected by port bit
  function automatic logic [15:0] put_byte(
    input logic [15:0] word,
    input logic port,
    input logic [7:0] b
  );
    put_byte = port ? {b, word[7:0]} : {word[15:8], b};
  endfunction : put_byte

  logic [15:0] pins;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic addr_hit;

  // edges and bus conditions on the synchronised lines
  assign pins = syn[iox_pkg::SY_PINS +: 16];
  assign scl = syn[iox_pkg::SY_SCL];
  assign sda = syn[iox_pkg::SY_SDA];
  assign scl_rise = scl & ~s_q.scl_p;
  assign scl_fall = ~scl & s_q.scl_p;
  assign start_c = scl & s_q.scl_p & s_q.sda_p & ~sda;
  assign stop_c = scl & s_q.scl_p & ~s_q.sda_p & sda;
  assign addr_hit = s_q.sh[7:1] == {iox_pkg::DEV_ADDR_HI,
                                     syn[iox_pkg::SY_ADDR]};

  // next state of the whole block
  always_comb begin
    s_d = s_q;
    s_d.scl_p = scl;
    s_d.sda_p = sda;
    // first cycle after reset: take the present pins as reference
    if (!s_q.init) begin
      s_d.init = 1'b1;
      s_d.snap = pins;
      s_d.inr = pins;
    end
    if (start_c) begin
      // a start or repeated start opens a new address phase
      s_d.st = iox_pkg::ST_ADDR; // RQ12
      s_d.cnt = 4'h0;
      s_d.sda_oe = 1'b0;
    end else if (stop_c) begin
      s_d.st = iox_pkg::ST_IDLE;
      s_d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (s_q.st)
        iox_pkg::ST_ADDR, iox_pkg::ST_CMD, iox_pkg::ST_WR: begin
          s_d.sh = {s_q.sh[6:0], sda};
          s_d.cnt = s_q.cnt + 4'h1;
        end
        iox_pkg::ST_AACK: begin
          if (s_q.rw) begin
            s_d.inr = pins; // RQ20
          end
        end
        iox_pkg::ST_RACK: begin
          // master answer, input capture, read clear, pair toggle
          s_d.rw = ~sda; // RQ18
          s_d.inr = pins; // RQ20
          if (s_q.ptr[2:1] == 2'h0) begin
            s_d.snap = put_byte(s_q.snap, s_q.ptr[0],
                                s_q.ptr[0] ? s_q.inr[15:8] : s_q.inr[7:0]); // RQ7
          end
          s_d.ptr = {s_q.ptr[2:1], ~s_q.ptr[0]}; // RQ17 RQ19
        end
        default: begin
          s_d.st = s_q.st;
        end
      endcase
    end else if (scl_fall) begin
      case (s_q.st)
        iox_pkg::ST_ADDR: begin
          if (s_q.cnt == iox_pkg::BITS_PER_BYTE) begin
            if (addr_hit) begin
              s_d.st = iox_pkg::ST_AACK;
              s_d.rw = s_q.sh[0]; // RQ13 RQ16
              s_d.sda_oe = 1'b1;
            end else begin
              s_d.st = iox_pkg::ST_IDLE;
            end
          end
        end
        iox_pkg::ST_AACK: begin
          s_d.cnt = 4'h0;
          if (s_q.rw) begin
            // first read byte from the current pointer
            s_d.st = iox_pkg::ST_RD; // RQ16 RQ19
            s_d.sh = rd_byte(s_q.ptr, s_q.inr, s_q.outr, s_q.inv, s_q.cfg);
            s_d.sda_oe = ~s_d.sh[7];
          end else begin
            s_d.st = iox_pkg::ST_CMD;
            s_d.sda_oe = 1'b0;
          end
        end
        iox_pkg::ST_CMD: begin
          if (s_q.cnt == iox_pkg::BITS_PER_BYTE) begin
            s_d.ptr = s_q.sh[iox_pkg::PTR_W-1:0]; // RQ22 RQ13
            s_d.st = iox_pkg::ST_CACK;
            s_d.sda_oe = 1'b1;
          end
        end
        iox_pkg::ST_CACK, iox_pkg::ST_WACK: begin
          s_d.st = iox_pkg::ST_WR;
          s_d.cnt = 4'h0;
          s_d.sda_oe = 1'b0;
        end
        iox_pkg::ST_WR: begin
          if (s_q.cnt == iox_pkg::BITS_PER_BYTE) begin
            // store the byte, then move to the other half of the pair
            case (s_q.ptr[2:1])
              2'h1: s_d.outr = put_byte(s_q.outr, s_q.ptr[0], s_q.sh);
              2'h2: s_d.inv = put_byte(s_q.inv, s_q.ptr[0], s_q.sh);
              2'h3: s_d.cfg = put_byte(s_q.cfg, s_q.ptr[0], s_q.sh); // RQ23
              default: s_d.outr = s_q.outr; // input pair is read only
            endcase
            s_d.ptr = {s_q.ptr[2:1], ~s_q.ptr[0]}; // RQ14 RQ15
            s_d.st = iox_pkg::ST_WACK;
            s_d.sda_oe = 1'b1;
          end
        end
        iox_pkg::ST_RD: begin
          if (s_q.cnt == 4'h7) begin
            s_d.st = iox_pkg::ST_RACK;
            s_d.sda_oe = 1'b0;
          end else begin
            s_d.sh = {s_q.sh[6:0], 1'b0};
            s_d.sda_oe = ~s_q.sh[6];
          end
          s_d.cnt = s_q.cnt + 4'h1;
        end
        iox_pkg::ST_RACK: begin
          s_d.cnt = 4'h0;
          if (s_q.rw) begin
            // acknowledged: next byte from the other register
            s_d.st = iox_pkg::ST_RD; // RQ17
            s_d.sh = rd_byte(s_q.ptr, s_q.inr, s_q.outr, s_q.inv, s_q.cfg);
            s_d.sda_oe = ~s_d.sh[7];
          end else begin
            s_d.st = iox_pkg::ST_IDLE; // RQ18
            s_d.sda_oe = 1'b0;
          end
        end
        default: begin
          s_d.st = s_q.st;
        end
      endcase
    end
    // alert while an input-configured pin differs from the snapshot
    s_d.int_oe = s_q.init &&
                 ((pins ^ s_d.snap) & s_d.cfg) != 16'h0000; // RQ4 RQ6 RQ8 RQ9 RQ10 RQ26 RQ5
    s_d.p_oe = ~s_d.cfg; // RQ23
  end

  // registers; the reset pin has the same effect as the power-on reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !syn[iox_pkg::SY_RSTP]) begin // RQ2 RQ21 RQ3
      s_q.st <= iox_pkg::ST_IDLE;
      s_q.cnt <= 4'h0;
      s_q.sh <= 8'h00;
      s_q.rw <= 1'b0;
      s_q.ptr <= iox_pkg::PTR_IN0;
      s_q.outr <= iox_pkg::OUT_RST;
      s_q.inv <= iox_pkg::INV_RST;
      s_q.cfg <= iox_pkg::CFG_RST;
      s_q.inr <= 16'h0000;
      s_q.snap <= 16'h0000;
      s_q.init <= 1'b0;
      s_q.scl_p <= 1'b1;
      s_q.sda_p <= 1'b1;
      s_q.sda_oe <= 1'b0;
      s_q.int_oe <= 1'b0;
      s_q.p_oe <= ~iox_pkg::CFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // open-drain lines only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_o = s_q.sda_oe;
  assign alert_n_o = 1'b0; // RQ11
  assign alert_n_oe_o = s_q.int_oe; // RQ11
  assign port_o = s_q.outr;
  assign port_oe_o = s_q.p_oe;

endmodule : iox_core

// File: src/iox_pkg.sv
package iox_pkg;

  // synchroniser vector layout
  localparam int SYNC_W = 20;
  localparam int SY_PINS = 0;
  localparam int SY_SCL = 16;
  localparam int SY_SDA = 17;
  localparam int SY_RSTP = 18;
  localparam int SY_ADDR = 19;
  localparam logic [SYNC_W-1:0] SYNC_RST = 20'h70000;

  // bus address: upper six bits fixed, lowest bit from the address pin
  localparam logic [5:0] DEV_ADDR_HI = 6'h10;

  // command pointer values
  localparam logic [2:0] PTR_IN0 = 3'h0;
  localparam logic [2:0] PTR_IN1 = 3'h1;
  localparam logic [2:0] PTR_OUT0 = 3'h2;
  localparam logic [2:0] PTR_OUT1 = 3'h3;
  localparam logic [2:0] PTR_INV0 = 3'h4;
  localparam logic [2:0] PTR_INV1 = 3'h5;
  localparam logic [2:0] PTR_CFG0 = 3'h6;
  localparam logic [2:0] PTR_CFG1 = 3'h7;
  localparam int PTR_W = 3;

  // reset values
  localparam logic [15:0] OUT_RST = 16'hffff;
  localparam logic [15:0] INV_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'hffff;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_AACK = 9'h004,
    ST_CMD = 9'h008,
    ST_CACK = 9'h010,
    ST_WR = 9'h020,
    ST_WACK = 9'h040,
    ST_RD = 9'h080,
    ST_RACK = 9'h100
  } iox_state_e;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] q;
  } iox_sync_s;

  typedef struct packed {
    iox_state_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [PTR_W-1:0] ptr;
    logic [15:0] outr;
    logic [15:0] inv;
    logic [15:0] cfg;
    logic [15:0] inr;
    logic [15:0] snap;
    logic init;
    logic scl_p;
    logic sda_p;
    logic sda_oe;
    logic int_oe;
    logic [15:0] p_oe;
  } iox_core_s;

endpackage : iox_pkg

// File: src/iox_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; a bit changes once stages two and three agree
module iox_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [iox_pkg::SYNC_W-1:0] d_i,
  output logic [iox_pkg::SYNC_W-1:0] q_o
);

  iox_pkg::iox_sync_s s_q;
  iox_pkg::iox_sync_s s_d;

  // stage one feeds only stage two
  always_comb begin
    s_d = s_q;
    s_d.s1 = d_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.q = (s_q.s2 & ~(s_q.s2 ^ s_q.s3)) | (s_q.q & (s_q.s2 ^ s_q.s3));
  end

  // registers with synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= {4{iox_pkg::SYNC_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.q;

endmodule : iox_sync

// File: test/iox_core_sva.sv
`timescale 1ns/1ps
// pin-level checks on bus, alert and reset behaviour of the core
module iox_core_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reset_pin_n_i,
  input wire logic addr_sel_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [15:0] port_i,
  input wire logic [15:0] port_o,
  input wire logic [15:0] port_oe_o,
  input wire logic alert_n_o,
  input wire logic alert_n_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // reset pin held long enough to pass the synchroniser, then let go
  sequence s_pin_pulse;
    (!reset_pin_n_i) [*6] ##1 reset_pin_n_i;
  endsequence
  // every port pin driven for a while
  sequence s_all_out;
    (port_oe_o == 16'hffff) [*8];
  endsequence
  chk_rst_quiet: assert property ($rose(rst_n_i) |->
    !sda_oe_o && !alert_n_oe_o && port_o == 16'hffff && port_oe_o == 16'h0)
    else $error("outputs not at defaults after power-on reset");
  chk_pin_reset: assert property (s_pin_pulse |->
    port_o == 16'hffff && port_oe_o == 16'h0000 && !sda_oe_o)
    else $error("reset pin did not restore defaults");
  chk_alert_od: assert property (alert_n_o == 1'b0)
    else $error("alert line driven high");
  chk_sda_od: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  chk_sda_scl: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line moved while bus clock high");
  chk_port_bus: assert property (
    $changed(port_o) || $changed(port_oe_o) |-> !scl_i || !reset_pin_n_i)
    else $error("port changed outside a write or reset");
  chk_out_quiet: assert property (s_all_out |-> !alert_n_oe_o)
    else $error("alert raised with every pin an output");
  chk_alert_idle: assert property ($rose(alert_n_oe_o) |->
    $past(port_i, 3) != $past(port_i, 8) || $rose(port_oe_o != 16'hffff)
    || $past(port_oe_o, 3) != port_oe_o || $past(scl_i, 4))
    else $error("alert raised with no input change");
endmodule : iox_core_chk

bind iox_core iox_core_chk u_iox_core_chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .reset_pin_n_i(reset_pin_n_i),
  .addr_sel_i(addr_sel_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .port_i(port_i), .port_o(port_o),
  .port_oe_o(port_oe_o), .alert_n_o(alert_n_o),
  .alert_n_oe_o(alert_n_oe_o));

// File: test/iox_mst.sv
`timescale 1ns/1ps
// bus master model; its clock line only moves inside frames
module iox_mst (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // one phase of the bus clock
  task automatic hp();
    repeat (10) @(negedge clk_i);
  endtask : hp
  // start or repeated start, only from idle or after a ninth bit
  task automatic start();
    sda_pull_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_pull_o = 1'b1;
    hp();
    scl_o = 1'b0;
  endtask : start
  // stop leaves both lines released
  task automatic stop();
    repeat (3) @(negedge clk_i);
    sda_pull_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_pull_o = 1'b0;
    hp();
  endtask : stop
  // data set while clock low, sampled at the end of clock high
  task automatic bitx(input logic b, output logic r);
    repeat (3) @(negedge clk_i);
    sda_pull_o = ~b;
    hp();
    scl_o = 1'b1;
    hp();
    r = sda_i;
    scl_o = 1'b0;
  endtask : bitx
  // byte msb first, then ninth bit; a high ends a read
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(a, k);
  endtask : xfer
endmodule : iox_mst

// File: test/tb_iox_core.sv
`timescale 1ns/1ps
// self-checking bench for the expander core
module tb_iox_core;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rpin_n = 1'b1;
  logic asel = 1'b0;
  logic [15:0] pv = 16'h0000;
  logic [15:0] inv = 16'h0000;
  logic [7:0] a, b, c, q;
  logic k;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 32;
  int cyc = 0;
  int r;
  wire scl, pull, sda_oe, alert_oe, sda;
  wire [15:0] p_out, p_oe, pins;
  // open-drain data wire and port pins from every driver
  assign sda = ~(pull | sda_oe);
  assign pins = (p_oe & p_out) | (~p_oe & pv);
  iox_core u_iox_core (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reset_pin_n_i(rpin_n), .addr_sel_i(asel), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(sda_oe), .port_i(pins), .port_o(p_out),
    .port_oe_o(p_oe), .alert_n_o(), .alert_n_oe_o(alert_oe));
  iox_mst u_iox_mst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
    .sda_pull_o(pull));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // expected input byte of one port after inversion
  function automatic logic [7:0] in_byte(input logic p);
    logic [15:0] v;
    v = pv ^ inv;
    return p ? v[15:8] : v[7:0];
  endfunction : in_byte
  // start and address; rw high reads
  task automatic go(input logic rw);
    u_iox_mst.start();
    u_iox_mst.xfer({iox_pkg::DEV_ADDR_HI, asel, rw}, 1'b1, q, k);
    chk({15'h0, k}, 16'h0000);
  endtask : go
  task automatic wb(input logic [7:0] d);
    u_iox_mst.xfer(d, 1'b1, q, k);
    chk({15'h0, k}, 16'h0000);
  endtask : wb
  task automatic rb(input logic n, input logic [7:0] e);
    u_iox_mst.xfer(8'hff, n, q, k);
    chk({8'h00, q}, {8'h00, e});
  endtask : rb
  initial begin
    asel = 1'($random(seed));
    a = 8'($random(seed));
    b = 8'($random(seed));
    c = 8'($random(seed));
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (8) @(negedge clk_i);
    // direction pair written high byte first, then all outputs
    go(1'b0);
    wb(8'h07);
    wb(a);
    wb(b);
    u_iox_mst.stop();
    chk(p_oe, ~{a, b});
    go(1'b0);
    wb(8'h06);
    wb(8'h00);
    wb(8'h00);
    u_iox_mst.stop();
    chk(p_oe, 16'hffff);
    $display("test 1 done");
    // three bytes alternate in the output pair, then read back
    go(1'b0);
    wb(8'h03);
    wb(a);
    wb(b);
    wb(c);
    u_iox_mst.stop();
    chk(p_out, {c, b});
    chk({15'h0, alert_oe}, 16'h0000);
    go(1'b0);
    wb(8'h02);
    go(1'b1);
    rb(1'b0, b);
    rb(1'b0, c);
    rb(1'b1, b);
    go(1'b1);
    rb(1'b1, c);
    u_iox_mst.stop();
    $display("test 2 done");
    // inputs with random inversion, alert raised and cleared
    inv = 16'($random(seed));
    go(1'b0);
    wb(8'h04);
    wb(inv[7:0]);
    wb(inv[15:8]);
    go(1'b0);
    wb(8'h06);
    wb(8'hff);
    wb(8'hff);
    u_iox_mst.stop();
    pv = 16'($random(seed));
    go(1'b0);
    wb(8'h00);
    go(1'b1);
    rb(1'b0, in_byte(1'b0));
    rb(1'b1, in_byte(1'b1));
    u_iox_mst.stop();
    chk({15'h0, alert_oe}, 16'h0000);
    r = {$random(seed)} % 16;
    for (int j = 0; j < 4; j++) begin
      pv[r] = ~pv[r];
      repeat (12) @(negedge clk_i);
      chk({15'h0, alert_oe}, {15'h0, j != 1});
      if (j == 2) begin
        go(1'b0);
        wb({7'h00, r[3]});
        go(1'b1);
        rb(1'b1, in_byte(r[3]));
        u_iox_mst.stop();
        chk({15'h0, alert_oe}, 16'h0000);
      end
    end
    $display("test 3 done");
    // reset pin pulse restores defaults
    rpin_n = 1'b0;
    repeat (8) @(negedge clk_i);
    rpin_n = 1'b1;
    repeat (8) @(negedge clk_i);
    chk(p_out, iox_pkg::OUT_RST);
    chk(p_oe, ~iox_pkg::CFG_RST);
    go(1'b0);
    wb(8'h05);
    go(1'b1);
    rb(1'b1, iox_pkg::INV_RST[15:8]);
    u_iox_mst.stop();
    // a frame for the other address must go unanswered
    u_iox_mst.start();
    u_iox_mst.xfer({iox_pkg::DEV_ADDR_HI, ~asel, 1'b0}, 1'b1, q, k);
    u_iox_mst.stop();
    chk({15'h0, k}, 16'h0001);
    $display("test 4 done");
    report_and_stop();
  end
endmodule : tb_iox_core
